/* File: hdl/dpcl_cfg.svh */
`ifndef DPCL_CFG_SVH
`define DPCL_CFG_SVH

`define DPCL_CLK_NS         8
`define DPCL_TICK_CYC       125
`define DPCL_BOOST_WIN_US   2000
`define DPCL_BOOST_REARM_US 16000
`define DPCL_OC_LIMIT_US    4100
`define DPCL_HICCUP_OFF_US  524000
`define DPCL_FAST_OFF_US    2
`define DPCL_SOFTSTART_US   1000
`define DPCL_TON_MIN_NS     84
`define DPCL_TOFF_MIN_NS    81
`define DPCL_TON_MIN_CYC    ((`DPCL_TON_MIN_NS + `DPCL_CLK_NS - 1) / `DPCL_CLK_NS)
`define DPCL_TOFF_MIN_CYC   ((`DPCL_TOFF_MIN_NS + `DPCL_CLK_NS - 1) / `DPCL_CLK_NS)
`define DPCL_FOLD_QUIET     16

`define DPCL_ADDR_CTRL      12'h000
`define DPCL_ADDR_STATUS    12'h004
`define DPCL_ADDR_INT_STAT  12'h008
`define DPCL_ADDR_INT_MASK  12'h00C
`define DPCL_CTRL_RESET     3'h7
`define DPCL_MASK_RESET     8'h00

`endif

/* File: hdl/dpcl_pkg.sv */
package dpcl_pkg;
    typedef enum logic [1:0] { BST_WINDOW, BST_REARM, BST_ARMED } dpcl_boost_type;
    typedef enum logic [2:0] { PS_RUN, PS_FAST_OFF, PS_SOFTSTART, PS_HICCUP, PS_THERMAL }
        dpcl_port_type;
    typedef enum logic [1:0] { VSEL_5V10, VSEL_5V17, VSEL_5V30, VSEL_5V40 } dpcl_vsel_type;
endpackage

/* File: hdl/dpcl_top.sv */
// How it works
// - Fixed primary limit per port, independently
// - Boosted limit 1.6x, in window and while armed
// - Boost held 2 ms after power-up
// - Boost not re-armed for 16 ms
// - Above boosted limit: primary at once
// - Between limits: allow window, then clamp
// - Short threshold: fast off, soft restart
// - Limited port held at constant primary current
// - Limit over 4.1 ms: hiccup 524/5.1
// - Faults confined to the faulted port
// - Either port over primary: other primary
// - Hot switch off until cooled, restart
// - Minimum high-side on and off times
// - Fold frequency when limits bind
// - Decode select pin into four targets
`timescale 1ns/1ns
`include "dpcl_cfg.svh"
module dpcl_top
    import dpcl_pkg::*;
#(
    parameter int TICK_CYC     = `DPCL_TICK_CYC,
    parameter int BOOST_WIN_US = `DPCL_BOOST_WIN_US,
    parameter int REARM_US     = `DPCL_BOOST_REARM_US,
    parameter int OC_US        = `DPCL_OC_LIMIT_US,
    parameter int HICCUP_US    = `DPCL_HICCUP_OFF_US,
    parameter int FAST_OFF_US  = `DPCL_FAST_OFF_US,
    parameter int SOFTSTART_US = `DPCL_SOFTSTART_US
)(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        power_good,
    input  wire logic [1:0]  port_uvlo,
    input  wire logic [1:0]  over_primary,
    input  wire logic [1:0]  over_boosted,
    input  wire logic [1:0]  over_short,
    input  wire logic [1:0]  switch_hot,
    input  wire logic [1:0]  switch_cooled,
    input  wire logic [1:0]  output_level_select_pin,
    input  wire logic        hs_demand,
    input  wire logic        cycle_start,
    output logic [1:0]       port_power_switch,
    output logic [1:0]       boosted_port_limit,
    output logic [1:0]       primary_clamp,
    output logic [1:0]       soft_start,
    output logic [1:0]       output_level,
    output logic             high_side_switch,
    output logic [1:0]       fold_level
);
    localparam int TW = 20;
    localparam logic [TW-1:0] WIN_T  = TW'(BOOST_WIN_US);
    localparam logic [TW-1:0] RARM_T = TW'(REARM_US);
    localparam logic [TW-1:0] OC_T   = TW'(OC_US);
    localparam logic [TW-1:0] HIC_T  = TW'(HICCUP_US);
    localparam logic [TW-1:0] FOFF_T = TW'(FAST_OFF_US);
    localparam logic [TW-1:0] SS_T   = TW'(SOFTSTART_US);
    localparam logic [3:0] TON_MIN   = 4'(`DPCL_TON_MIN_CYC);
    localparam logic [3:0] TOFF_MIN  = 4'(`DPCL_TOFF_MIN_CYC);
    localparam logic [4:0] FOLD_Q    = 5'(`DPCL_FOLD_QUIET);

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    logic [6:0]  tick_cnt_r;
    logic        tick_r;
    logic [2:0]  ctrl_r;
    logic [7:0]  int_stat_r;
    logic [7:0]  int_mask_r;
    logic [7:0]  int_evt;
    logic [31:0] status;
    logic        rd_acc;
    logic        wr_acc;
    logic        addr_ok;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_r <= 7'h00;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == 7'(TICK_CYC - 1))
        begin
            tick_cnt_r <= 7'h00;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 7'h01;
            tick_r     <= 1'b0;
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            dpcl_boost_type bst_r;
            dpcl_port_type  ps_r;
            logic [TW-1:0]  bst_cnt_r;
            logic [TW-1:0]  oc_cnt_r;
            logic [TW-1:0]  ps_cnt_r;
            logic           hold;
            logic           boost_on;
            logic           limited;
            logic           enabled;

            // Port state reset to soft start and boost window while unpowered or in UVLO
            assign hold     = !power_good || port_uvlo[p];
            assign enabled  = ctrl_r[p];
            // Other port over primary forces primary here
            assign boost_on = (bst_r != BST_REARM) && !over_primary[1-p];
            assign limited  = boost_on ? over_boosted[p] : over_primary[p];

            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    bst_r     <= BST_WINDOW;
                    bst_cnt_r <= '0;
                end
                else if (hold)
                begin
                    bst_r     <= BST_WINDOW;
                    bst_cnt_r <= '0;
                end
                else
                begin
                    case (bst_r)
                        BST_WINDOW:
                        begin
                            // Excess over boosted limit ends window now
                            if (over_boosted[p] || (tick_r && bst_cnt_r >= WIN_T - 1'b1))
                            begin
                                bst_r     <= BST_REARM;
                                bst_cnt_r <= '0;
                            end
                            else if (tick_r)
                                bst_cnt_r <= bst_cnt_r + 1'b1;
                        end
                        BST_REARM:
                        begin
                            if (tick_r && bst_cnt_r >= RARM_T - 1'b1)
                            begin
                                bst_r     <= BST_ARMED;
                                bst_cnt_r <= '0;
                            end
                            else if (tick_r)
                                bst_cnt_r <= bst_cnt_r + 1'b1;
                        end
                        BST_ARMED:
                        begin
                            // Overload between limits opens a new window
                            if (over_boosted[p])
                                bst_r <= BST_REARM;
                            else if (over_primary[p])
                                bst_r <= BST_WINDOW;
                        end
                        default:
                            bst_r <= BST_REARM;
                    endcase
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    oc_cnt_r <= '0;
                else if (hold || !limited || ps_r != PS_RUN)
                    oc_cnt_r <= '0;
                else if (tick_r)
                    oc_cnt_r <= oc_cnt_r + 1'b1;
            end

            // Fault sequencing local to this port
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    ps_r     <= PS_SOFTSTART;
                    ps_cnt_r <= '0;
                end
                else if (hold)
                begin
                    ps_r     <= PS_SOFTSTART;
                    ps_cnt_r <= '0;
                end
                else if (switch_hot[p] && ps_r != PS_THERMAL)
                    ps_r <= PS_THERMAL;
                else
                begin
                    case (ps_r)
                        PS_RUN:
                        begin
                            ps_cnt_r <= '0;
                            if (over_short[p])
                                ps_r <= PS_FAST_OFF;
                            else if (oc_cnt_r >= OC_T)
                                ps_r <= PS_HICCUP;
                        end
                        PS_FAST_OFF:
                        begin
                            if (tick_r && ps_cnt_r >= FOFF_T - 1'b1)
                            begin
                                ps_r     <= PS_SOFTSTART;
                                ps_cnt_r <= '0;
                            end
                            else if (tick_r)
                                ps_cnt_r <= ps_cnt_r + 1'b1;
                        end
                        PS_SOFTSTART:
                        begin
                            if (over_short[p])
                            begin
                                ps_r     <= PS_FAST_OFF;
                                ps_cnt_r <= '0;
                            end
                            else if (tick_r && ps_cnt_r >= SS_T - 1'b1)
                            begin
                                ps_r     <= PS_RUN;
                                ps_cnt_r <= '0;
                            end
                            else if (tick_r)
                                ps_cnt_r <= ps_cnt_r + 1'b1;
                        end
                        PS_HICCUP:
                        begin
                            // Retry restarts the limit timer: next on-phase is the 1 ms soft start plus 4.1 ms
                            if (tick_r && ps_cnt_r >= HIC_T - 1'b1)
                            begin
                                ps_r     <= PS_SOFTSTART;
                                ps_cnt_r <= '0;
                            end
                            else if (tick_r)
                                ps_cnt_r <= ps_cnt_r + 1'b1;
                        end
                        PS_THERMAL:
                        begin
                            if (switch_cooled[p] && !switch_hot[p])
                            begin
                                ps_r     <= PS_SOFTSTART;
                                ps_cnt_r <= '0;
                            end
                        end
                        default:
                            ps_r <= PS_SOFTSTART;
                    endcase
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    port_power_switch[p]  <= 1'b0;
                    boosted_port_limit[p] <= 1'b0;
                    primary_clamp[p]      <= 1'b0;
                    soft_start[p]         <= 1'b0;
                end
                else
                begin
                    port_power_switch[p]  <= !hold && enabled &&
                        (ps_r == PS_RUN || ps_r == PS_SOFTSTART);
                    boosted_port_limit[p] <= !hold && boost_on;
                    // Primary clamp when over the primary limit with boost off
                    primary_clamp[p]      <= !hold && limited && !boost_on;
                    soft_start[p]         <= !hold && ps_r == PS_SOFTSTART;
                end
            end

            assign int_evt[p]     = ps_r == PS_RUN && over_short[p];
            assign int_evt[p + 2] = ps_r == PS_RUN && oc_cnt_r >= OC_T;
            assign int_evt[p + 4] = ps_r != PS_THERMAL && switch_hot[p];
            assign int_evt[p + 6] = bst_r == BST_WINDOW && over_boosted[p] && !hold;
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            output_level <= VSEL_5V10;
        else
            case (output_level_select_pin)
                2'h0:    output_level <= VSEL_5V10;
                2'h1:    output_level <= VSEL_5V17;
                2'h2:    output_level <= VSEL_5V30;
                2'h3:    output_level <= VSEL_5V40;
                default: output_level <= VSEL_5V10;
            endcase
    end

    logic [3:0] on_cnt_r;
    logic [3:0] off_cnt_r;
    logic [2:0] skip_r;
    logic [4:0] quiet_r;
    logic       allow;
    logic       viol;
    logic       start_ok;

    assign allow    = skip_r == 3'h0;
    assign start_ok = cycle_start && allow && hs_demand;
    // A turn-on blocked by off time, or a turn-off blocked by on time
    assign viol = (!high_side_switch && start_ok && off_cnt_r < TOFF_MIN) ||
                  (high_side_switch && !hs_demand && on_cnt_r < TON_MIN);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_side_switch <= 1'b0;
            on_cnt_r         <= 4'h0;
            off_cnt_r        <= TOFF_MIN;
        end
        else if (high_side_switch)
        begin
            if (!hs_demand && on_cnt_r >= TON_MIN)
            begin
                high_side_switch <= 1'b0;
                off_cnt_r        <= 4'h1;
            end
            else if (on_cnt_r < TON_MIN)
                on_cnt_r <= on_cnt_r + 4'h1;
        end
        else
        begin
            if (start_ok && off_cnt_r >= TOFF_MIN)
            begin
                high_side_switch <= 1'b1;
                on_cnt_r         <= 4'h1;
            end
            else if (off_cnt_r < TOFF_MIN)
                off_cnt_r <= off_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fold_level <= 2'h0;
            skip_r     <= 3'h0;
            quiet_r    <= 5'h00;
        end
        else
        begin
            if (cycle_start)
                skip_r <= allow ? 3'((4'h1 << fold_level) - 4'h1) : skip_r - 3'h1;
            if (viol && ctrl_r[2])
            begin
                quiet_r <= 5'h00;
                if (fold_level != 2'h3)
                    fold_level <= fold_level + 2'h1;
            end
            else if (cycle_start && allow)
            begin
                if (quiet_r >= FOLD_Q - 5'h01)
                begin
                    quiet_r <= 5'h00;
                    if (fold_level != 2'h0)
                        fold_level <= fold_level - 2'h1;
                end
                else
                    quiet_r <= quiet_r + 5'h01;
            end
        end
    end

    assign status = {20'h0_0000, fold_level, output_level, soft_start,
                     primary_clamp, boosted_port_limit, port_power_switch};
    assign addr_ok = paddr == `DPCL_ADDR_CTRL || paddr == `DPCL_ADDR_STATUS ||
                     paddr == `DPCL_ADDR_INT_STAT || paddr == `DPCL_ADDR_INT_MASK;
    assign wr_acc  = psel && penable && pwrite && addr_ok;
    assign rd_acc  = psel && penable && !pwrite && paddr == `DPCL_ADDR_INT_STAT;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r     <= `DPCL_CTRL_RESET;
            int_mask_r <= `DPCL_MASK_RESET;
        end
        else if (wr_acc && paddr == `DPCL_ADDR_CTRL)
            ctrl_r <= pwdata[2:0];
        else if (wr_acc && paddr == `DPCL_ADDR_INT_MASK)
            int_mask_r <= pwdata[7:0];
    end

    // New events win over the read clear
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            int_stat_r <= 8'h00;
        else
            int_stat_r <= (rd_acc ? 8'h00 : int_stat_r) | int_evt;
    end

    // Read data latched in setup so the access phase needs no wait
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            irq    <= |(int_stat_r & int_mask_r);
            if (psel && !penable)
            begin
                pslverr <= !addr_ok;
                case (paddr)
                    `DPCL_ADDR_CTRL:     prdata <= {29'h0, ctrl_r};
                    `DPCL_ADDR_STATUS:   prdata <= status;
                    `DPCL_ADDR_INT_STAT: prdata <= {24'h0, int_stat_r};
                    `DPCL_ADDR_INT_MASK: prdata <= {24'h0, int_mask_r};
                    default:             prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* File: bench/dpcl_monitor.sv */
`timescale 1ns/1ns
module dpcl_monitor
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       pready,
    input wire logic       irq,
    input wire logic [1:0] over_primary,
    input wire logic [1:0] over_boosted,
    input wire logic [1:0] over_short,
    input wire logic [1:0] switch_hot,
    input wire logic       high_side_switch,
    input wire logic [1:0] port_power_switch,
    input wire logic [1:0] boosted_port_limit
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    bus_ready_a:
        assert property ($past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n) |-> pready)
        else $error("pready low after reset release");
    lock_port0_a:
        assert property (over_primary[1] |=> !boosted_port_limit[0])
        else $error("port 0 kept boost while port 1 over primary");
    lock_port1_a:
        assert property (over_primary[0] |=> !boosted_port_limit[1])
        else $error("port 1 kept boost while port 0 over primary");
    boost_cut_a:
        assert property (over_boosted[1] |-> ##[1:2] !boosted_port_limit[1])
        else $error("boost kept above boosted limit");
    min_on_a:
        assert property ($rose(high_side_switch) |-> high_side_switch[*8] ##1 high_side_switch[*3])
        else $error("high side on interval too short");
    min_off_a:
        assert property ($fell(high_side_switch) |-> !high_side_switch[*8] ##1 !high_side_switch[*3])
        else $error("high side off interval too short");
    short_off_a:
        assert property (over_short[1] && port_power_switch[1] |-> ##[1:2] !port_power_switch[1])
        else $error("short did not open the port switch");
    hot_off_a:
        assert property (switch_hot[1] && port_power_switch[1] |-> ##[1:2] !port_power_switch[1])
        else $error("hot switch stayed on");

    boost_c: cover property ($rose(boosted_port_limit[1]));
    hs_c: cover property ($rose(high_side_switch));
    irq_c: cover property ($rose(irq));
endmodule

bind dpcl_top dpcl_monitor mon
(
    .clk_sys(clk_sys), .reset_n(reset_n), .pready(pready), .irq(irq),
    .over_primary(over_primary), .over_boosted(over_boosted), .over_short(over_short),
    .switch_hot(switch_hot), .high_side_switch(high_side_switch),
    .port_power_switch(port_power_switch), .boosted_port_limit(boosted_port_limit)
);

/* File: bench/dpcl_load_model.sv */
`timescale 1ns/1ns
module dpcl_load_model
(
    input  wire logic       clk_sys,
    input  wire logic [3:0] load_level,
    input  wire logic [1:0] overheat,
    input  wire logic [1:0] port_power_switch,
    output logic      [1:0] over_primary,
    output logic      [1:0] over_boosted,
    output logic      [1:0] over_short,
    output logic      [1:0] switch_hot,
    output logic      [1:0] switch_cooled
);
    initial
    begin
        over_primary  = 2'h0;
        over_boosted  = 2'h0;
        over_short    = 2'h0;
        switch_hot    = 2'h0;
        switch_cooled = 2'h3;
    end

    // Level per port: 0 light, 1 above primary, 2 above boosted, 3 short
    always @(posedge clk_sys)
    begin
        for (int p = 0; p < 2; p++)
        begin
            // An open switch carries no current, so no comparator trips
            over_primary[p]  <= port_power_switch[p] && load_level[2*p+:2] != 2'h0;
            over_boosted[p]  <= port_power_switch[p] && load_level[2*p+:2] >= 2'h2;
            over_short[p]    <= port_power_switch[p] && load_level[2*p+:2] == 2'h3;
            switch_hot[p]    <= overheat[p];
            switch_cooled[p] <= !overheat[p];
        end
    end
endmodule

/* File: bench/dpcl_tb_top.sv */
`timescale 1ns/1ns
module dpcl_tb_top;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        power_good, hs_demand, cycle_start, high_side_switch, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  port_uvlo, over_primary, over_boosted, over_short, switch_hot, switch_cooled;
    logic [1:0]  output_level_select_pin, port_power_switch, boosted_port_limit, primary_clamp;
    logic [1:0]  soft_start, output_level, fold_level, overheat;
    logic [3:0]  load_level;
    int          error_cnt, checked, n;

    // Fast-off and soft-start keep their full lengths
    dpcl_top #(.TICK_CYC(4), .BOOST_WIN_US(5), .REARM_US(10), .OC_US(8), .HICCUP_US(20)) uut
    (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .power_good(power_good), .port_uvlo(port_uvlo),
        .over_primary(over_primary), .over_boosted(over_boosted), .over_short(over_short),
        .switch_hot(switch_hot), .switch_cooled(switch_cooled),
        .output_level_select_pin(output_level_select_pin), .hs_demand(hs_demand),
        .cycle_start(cycle_start), .port_power_switch(port_power_switch),
        .boosted_port_limit(boosted_port_limit), .primary_clamp(primary_clamp),
        .soft_start(soft_start), .output_level(output_level),
        .high_side_switch(high_side_switch), .fold_level(fold_level)
    );

    dpcl_load_model dev
    (
        .clk_sys(clk_sys), .load_level(load_level), .overheat(overheat),
        .port_power_switch(port_power_switch), .over_primary(over_primary),
        .over_boosted(over_boosted), .over_short(over_short), .switch_hot(switch_hot),
        .switch_cooled(switch_cooled)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
            begin
                error_cnt++;
                $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
            end
    endtask

    // Tasks start at a falling edge; all but drive_load end at one, where outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // The DUT holds pready high after reset, so this wait ends at once and no access is stretched
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic drive_load(input logic [3:0] v);
        @(posedge clk_sys);
        load_level <= v;
    endtask

    task automatic t_boost;
        check(32'(boosted_port_limit), 32'h3);
        cyc(32);
        check(32'(boosted_port_limit), 32'h0);
        drive_load(4'h1);
        cyc(6);
        check(32'(boosted_port_limit), 32'h0);
        drive_load(4'h0);
        cyc(40);
        drive_load(4'h4);
        cyc(4);
        check(32'(boosted_port_limit), 32'h2);
        drive_load(4'h5);
        cyc(3);
        check(32'(boosted_port_limit), 32'h0);
        drive_load(4'h0);
        // Limit timer only runs once the power-up soft start is over
        for (n = 0; n < 5000 && soft_start !== 2'h0; n++)
            @(negedge clk_sys);
        check(32'(soft_start), 32'h0);
        drive_load(4'h1);
        cyc(40);
        check(32'(primary_clamp), 32'h1);
        for (n = 0; n < 100 && port_power_switch[0] === 1'b1; n++)
            @(negedge clk_sys);
        check(32'(port_power_switch), 32'h2);
        drive_load(4'h0);
        for (n = 0; n < 200 && port_power_switch[0] !== 1'b1; n++)
            @(negedge clk_sys);
        check(32'(n > 70 && n < 92), 32'h1);
        check(32'(soft_start[0]), 32'h1);
    endtask

    task automatic t_irq;
        check(32'(irq), 32'h0);
        apb(1'b1, 12'h00C, 32'h4);
        cyc(2);
        check(32'(irq), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check(rd & 32'h4, 32'h4);
        cyc(2);
        check(32'(irq), 32'h0);
    endtask

    task automatic t_vsel;
        for (int p = 0; p < 4; p++)
        begin
            @(posedge clk_sys);
            output_level_select_pin <= 2'(p);
            cyc(2);
            check(32'(output_level), 32'(p));
        end
    endtask

    task automatic t_fault;
        drive_load(4'h8);
        cyc(4);
        check(32'({port_power_switch[1], boosted_port_limit[1]}), 32'h2);
        drive_load(4'hC);
        cyc(3);
        check(32'(port_power_switch), 32'h1);
        drive_load(4'h0);
        for (n = 0; n < 60 && port_power_switch[1] !== 1'b1; n++)
            @(negedge clk_sys);
        check(32'(soft_start[1]), 32'h1);
        @(posedge clk_sys);
        overheat <= 2'b10;
        cyc(20);
        check(32'(port_power_switch[1]), 32'h0);
        @(posedge clk_sys);
        overheat <= 2'b00;
        for (n = 0; n < 60 && port_power_switch[1] !== 1'b1; n++)
            @(negedge clk_sys);
        check(32'(port_power_switch[1]), 32'h1);
    endtask

    task automatic t_buck;
        @(posedge clk_sys);
        hs_demand   <= 1'b1;
        cycle_start <= 1'b1;
        @(posedge clk_sys);
        cycle_start <= 1'b0;
        // Demand drops at once, so only the minimum on time keeps it on
        hs_demand   <= 1'b0;
        cyc(4);
        check(32'(high_side_switch), 32'h1);
        cyc(12);
        check(32'(high_side_switch), 32'h0);
        check(32'(fold_level != 2'b00), 32'h1);
    endtask

    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h7);
        apb(1'b0, 12'h010, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        check(rd, 32'h4);
        @(posedge clk_sys);
        port_uvlo <= 2'b01;
        cyc(3);
        check(32'(port_power_switch[0]), 32'h0);
        @(posedge clk_sys);
        port_uvlo <= 2'b00;
        cyc(5);
        check(32'(boosted_port_limit[0]), 32'h1);
        @(posedge clk_sys);
        power_good <= 1'b0;
        cyc(3);
        check(32'({port_power_switch, boosted_port_limit}), 32'h0);
        @(posedge clk_sys);
        power_good <= 1'b1;
        apb(1'b1, 12'h000, 32'h0);
        cyc(3);
        check(32'(port_power_switch), 32'h0);
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Whole run is near 4300 cycles, mostly the power-up soft start
    initial
    begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial
    begin
        {reset_n, psel, penable, pwrite, hs_demand, cycle_start} = 6'h0;
        {paddr, pwdata} = 44'h0;
        {port_uvlo, output_level_select_pin, overheat, load_level} = 10'h0;
        power_good = 1'b1;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        cyc(3);
        t_boost();
        t_irq();
        t_vsel();
        t_fault();
        t_buck();
        t_regs();
        summarize();
    end
endmodule
